/* File: src/eifs_top.sv */
// external interrupt handling and feedback selection with AHB-Lite registers
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module eifs_top
  import eifs_pkg::*;
#(
  parameter int POS_W  = 32,
  parameter int RD_W   = 16,
  parameter int RATE_W = 16
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              ext_bus_irq_n,
  input  wire logic              ext_input_irq_n,
  input  wire logic [POS_W-1:0]  enc1_pos,
  input  wire logic [POS_W-1:0]  enc2_pos,
  input  wire logic [POS_W-1:0]  port_pos,
  input  wire logic [RD_W-1:0]   rd_raw,
  input  wire logic [RATE_W-1:0] rd_rate,
  input  wire logic              kernel_tick,
  input  wire logic              task1_end,
  input  wire logic              task2_done,
  input  wire logic              seq_active,
  input  wire logic              seq_last,
  output logic                   task1_hold,
  output logic                   task2_hold,
  output logic                   task2_restart,
  output logic                   kernel_realign,
  output logic                   final_segment_go,
  output logic [POS_W-1:0]       capture_pos,
  output logic [POS_W-1:0]       rd_pos,
  output eifs_rd_conv_t          rd_conv_sel,
  output logic [2:0]             vel_src_sel,
  output logic                   vel_fb_enable
);
`include "eifs_cfg.svh"

  typedef struct packed {
    logic [2:0]       cfg_mode;
    logic [2:0]       cfg_trig;
    logic [1:0]       cfg_src;
    logic [2:0]       cfg_res;
    logic [2:0]       cfg_vel;
    logic [2:0]       cfg_cap;
    logic [2:0]       w_mode;
    logic [2:0]       w_trig;
    logic [1:0]       w_src;
    logic [2:0]       w_res;
    logic [2:0]       w_vel;
    logic [2:0]       w_cap;
    eifs_t2_state_t   t2_st;
    logic             realign_pend;
    logic             irq_clear;
    logic             rd_14;
    logic             a_valid;
    logic             a_write;
    logic [7:0]       a_addr;
    logic [31:0]      hrdata;
    logic             hreadyout;
    logic             hresp;
    logic             task1_hold;
    logic             task2_hold;
    logic             task2_restart;
    logic             kernel_realign;
    logic             final_segment_go;
    logic [POS_W-1:0] capture_pos;
    logic [POS_W-1:0] rd_pos;
    eifs_rd_conv_t    rd_conv_sel;
    logic [2:0]       vel_src_sel;
    logic             vel_fb_enable;
  } eifs_top_state_t;

  eifs_top_state_t  st;
  eifs_top_state_t  next_st;
  logic             irq_line_n;
  logic             irq_event;
  logic             irq_pending;
  logic             ctl_rst;
  logic             addr_ph;
  logic [POS_W-1:0] raw_ext;
  logic [POS_W-1:0] rd_scaled;
  logic [POS_W-1:0] cap_val;
  logic [2:0]       f_mode;
  logic [2:0]       f_trig;
  logic [1:0]       f_src;
  logic [2:0]       f_res;
  logic [2:0]       f_vel;
  logic [2:0]       f_cap;

  function automatic logic [31:0] pack_cfg(input logic [2:0] m, input logic [2:0] t, input logic [1:0] s,
                                           input logic [2:0] r, input logic [2:0] v, input logic [2:0] c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`EIFS_F_MODE +: 3] = m;
    w[`EIFS_F_TRIG +: 3] = t;
    w[`EIFS_F_SRC  +: 2] = s;
    w[`EIFS_F_RES  +: 3] = r;
    w[`EIFS_F_VEL  +: 3] = v;
    w[`EIFS_F_CAP  +: 3] = c;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // interrupt line selection and qualification
  // ----------------------------------------------------------------
  assign irq_line_n = (st.w_src == `EIFS_SRC_XBUS) ? ext_bus_irq_n : ext_input_irq_n;

  eifs_irq_qual u_qual (
    .core_clk    (core_clk),
    .rst         (rst),
    .irq_line_n  (irq_line_n),
    .trig_type   (st.w_trig),
    .pend_clear  (st.irq_clear),
    .irq_event   (irq_event),
    .irq_pending (irq_pending)
  );

  // ----------------------------------------------------------------
  // feedback scaling and capture source
  // ----------------------------------------------------------------
  always_comb begin
    raw_ext = POS_W'(rd_raw);
    if ((st.w_res == `EIFS_RES_DYN) && st.rd_14) begin
      rd_scaled = {raw_ext[POS_W-3:0], 2'h0};
    end else begin
      rd_scaled = raw_ext;
    end
    if (st.w_cap == `EIFS_SEL_ENC2) begin
      cap_val = enc2_pos;
    end else if (st.w_cap == `EIFS_SEL_PORT) begin
      cap_val = port_pos;
    end else if (st.w_cap == `EIFS_SEL_RD) begin
      cap_val = rd_scaled;
    end else begin
      cap_val = enc1_pos;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st                  = st;
    next_st.task2_restart    = 1'h0;
    next_st.kernel_realign   = 1'h0;
    next_st.final_segment_go = 1'h0;
    next_st.irq_clear        = 1'h0;
    ctl_rst                  = 1'h0;
    f_mode                   = hwdata[`EIFS_F_MODE +: 3];
    f_trig                   = hwdata[`EIFS_F_TRIG +: 3];
    f_src                    = hwdata[`EIFS_F_SRC  +: 2];
    f_res                    = hwdata[`EIFS_F_RES  +: 3];
    f_vel                    = hwdata[`EIFS_F_VEL  +: 3];
    f_cap                    = hwdata[`EIFS_F_CAP  +: 3];

    // bus address phase; zero wait states
    addr_ph           = hsel && htrans[1] && hready;
    next_st.a_valid   = addr_ph;
    next_st.a_write   = hwrite && (hsize == `EIFS_HSIZE_WORD);
    next_st.a_addr    = haddr[7:0];
    next_st.hreadyout = 1'h1;
    next_st.hresp     = 1'h0;
    if (addr_ph && !hwrite) begin
      if (haddr[7:0] == `EIFS_OFS_CFG) begin
        next_st.hrdata = pack_cfg(st.cfg_mode, st.cfg_trig, st.cfg_src, st.cfg_res, st.cfg_vel, st.cfg_cap);
      end else if (haddr[7:0] == `EIFS_OFS_STATUS) begin
        next_st.hrdata = pack_cfg(st.w_mode, st.w_trig, st.w_src, st.w_res, st.w_vel, st.w_cap);
        next_st.hrdata[`EIFS_F_FLAGS +: 6] = {st.t2_st == T2_RUN, st.realign_pend, st.rd_14,
                                              st.task2_hold, st.task1_hold, irq_pending};
      end else if (haddr[7:0] == `EIFS_OFS_CAPTURE) begin
        next_st.hrdata = 32'(st.capture_pos);
      end else if (haddr[7:0] == `EIFS_OFS_RDPOS) begin
        next_st.hrdata = 32'(st.rd_pos);
      end else begin
        next_st.hrdata = 32'h0000_0000;
      end
    end

    // bus data phase; illegal field values leave the field unchanged
    if (st.a_valid && st.a_write) begin
      if (st.a_addr == `EIFS_OFS_CFG) begin
        if (f_mode <= `EIFS_MODE_TERM) begin
          next_st.cfg_mode = f_mode;
        end
        if ((f_trig >= `EIFS_TRIG_ULVL) && (f_trig <= `EIFS_TRIG_LEDGE)) begin
          next_st.cfg_trig = f_trig;
        end
        if ((f_src == `EIFS_SRC_XBUS) || (f_src == `EIFS_SRC_EXTIN)) begin
          next_st.cfg_src = f_src;
        end
        if ((f_res >= `EIFS_RES_16) && (f_res <= `EIFS_RES_DYN)) begin
          next_st.cfg_res = f_res;
        end
        if (f_vel <= `EIFS_SEL_RD) begin
          next_st.cfg_vel = f_vel;
        end
        if ((f_cap >= `EIFS_SEL_ENC1) && (f_cap <= `EIFS_SEL_RD)) begin
          next_st.cfg_cap = f_cap;
        end
      end else if (st.a_addr == `EIFS_OFS_CTRL) begin
        ctl_rst           = hwdata[`EIFS_C_CTLRST];
        next_st.irq_clear = hwdata[`EIFS_C_IRQCLR];
      end
    end

    if (ctl_rst) begin
      // controller reset: staged selections become the working set
      next_st.w_mode       = st.cfg_mode;
      next_st.w_trig       = st.cfg_trig;
      next_st.w_src        = st.cfg_src;
      next_st.w_res        = st.cfg_res;
      next_st.w_vel        = st.cfg_vel;
      next_st.w_cap        = st.cfg_cap;
      next_st.t2_st        = T2_HELD;
      next_st.realign_pend = 1'h0;
      next_st.irq_clear    = 1'h1;
      next_st.rd_14        = 1'h0;
    end else begin
      if (irq_event && (st.w_mode >= `EIFS_MODE_ICPT) && (st.w_mode <= `EIFS_MODE_CAPT)) begin
        next_st.capture_pos = cap_val;
      end
      case (st.w_mode)
        `EIFS_MODE_ICPT, `EIFS_MODE_HOLD, `EIFS_MODE_SYNC: begin
          case (st.t2_st)
            T2_HELD: begin
              if (irq_event) begin
                next_st.t2_st = T2_RUN;
              end
            end
            T2_RUN: begin
              if (task2_done) begin
                next_st.t2_st         = T2_HELD;
                next_st.task2_restart = 1'h1;
              end
            end
            default: begin
              next_st.t2_st = T2_FREE;
            end
          endcase
          if ((st.w_mode == `EIFS_MODE_ICPT) && task1_end && (st.t2_st == T2_HELD)) begin
            next_st.t2_st = T2_FREE;
          end
          if (st.w_mode == `EIFS_MODE_SYNC) begin
            if (st.realign_pend && kernel_tick) begin
              next_st.kernel_realign = 1'h1;
              next_st.realign_pend   = 1'h0;
            end
            if (irq_event) begin
              next_st.realign_pend = 1'h1;
            end
          end
        end
        `EIFS_MODE_TERM: begin
          if (irq_event && seq_active && !seq_last) begin
            next_st.final_segment_go = 1'h1;
          end
        end
        default: begin
          next_st.t2_st = T2_HELD;
        end
      endcase
    end

    // task gating follows the working mode
    next_st.task2_hold = ((next_st.w_mode == `EIFS_MODE_ICPT) || (next_st.w_mode == `EIFS_MODE_HOLD) ||
                          (next_st.w_mode == `EIFS_MODE_SYNC)) && (next_st.t2_st == T2_HELD);
    next_st.task1_hold = (next_st.w_mode == `EIFS_MODE_ICPT) && (next_st.t2_st == T2_RUN);

    // resolver tracking with hysteresis in dynamic mode
    if ((st.w_res == `EIFS_RES_DYN) && !ctl_rst) begin
      if (!st.rd_14 && (16'(rd_rate) > `EIFS_RD_UP_CPS)) begin
        next_st.rd_14 = 1'h1;
      end else if (st.rd_14 && (16'(rd_rate) < `EIFS_RD_DN_CPS)) begin
        next_st.rd_14 = 1'h0;
      end
    end else if (!ctl_rst) begin
      next_st.rd_14 = 1'h0;
    end
    case (next_st.w_res)
      `EIFS_RES_14: next_st.rd_conv_sel = RD_CONV_14;
      `EIFS_RES_12: next_st.rd_conv_sel = RD_CONV_12;
      `EIFS_RES_DYN: next_st.rd_conv_sel = next_st.rd_14 ? RD_CONV_14 : RD_CONV_16;
      default: next_st.rd_conv_sel = RD_CONV_16;
    endcase
    next_st.rd_pos        = rd_scaled;
    next_st.vel_src_sel   = next_st.w_vel;
    next_st.vel_fb_enable = next_st.w_vel != `EIFS_SEL_OFF;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st           <= '0;
      st.cfg_mode  <= `EIFS_RST_MODE;
      st.cfg_trig  <= `EIFS_RST_TRIG;
      st.cfg_src   <= `EIFS_RST_SRC;
      st.cfg_res   <= `EIFS_RST_RES;
      st.cfg_vel   <= `EIFS_RST_VEL;
      st.cfg_cap   <= `EIFS_RST_CAP;
      st.w_mode    <= `EIFS_RST_MODE;
      st.w_trig    <= `EIFS_RST_TRIG;
      st.w_src     <= `EIFS_RST_SRC;
      st.w_res     <= `EIFS_RST_RES;
      st.w_vel     <= `EIFS_RST_VEL;
      st.w_cap     <= `EIFS_RST_CAP;
      st.hreadyout <= 1'h1;
      st.vel_src_sel   <= `EIFS_RST_VEL;
      st.vel_fb_enable <= 1'h1;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata           = st.hrdata;
  assign hreadyout        = st.hreadyout;
  assign hresp            = st.hresp;
  assign task1_hold       = st.task1_hold;
  assign task2_hold       = st.task2_hold;
  assign task2_restart    = st.task2_restart;
  assign kernel_realign   = st.kernel_realign;
  assign final_segment_go = st.final_segment_go;
  assign capture_pos      = st.capture_pos;
  assign rd_pos           = st.rd_pos;
  assign rd_conv_sel      = st.rd_conv_sel;
  assign vel_src_sel      = st.vel_src_sel;
  assign vel_fb_enable    = st.vel_fb_enable;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  mode_off_free_a: assert property (@(posedge core_clk) disable iff (rst)
    st.w_mode == `EIFS_MODE_OFF |-> !task1_hold && !task2_hold)
    else $error("task held with interrupt off");
  t2_held_a: assert property (@(posedge core_clk) disable iff (rst)
    (st.w_mode == `EIFS_MODE_HOLD) && (st.t2_st == T2_HELD) && !irq_event && !ctl_rst |=> task2_hold)
    else $error("task 2 released without interrupt");
  t2_rearm_a: assert property (@(posedge core_clk) disable iff (rst)
    (st.w_mode == `EIFS_MODE_HOLD) && (st.t2_st == T2_RUN) && task2_done && !ctl_rst
    |=> task2_restart && task2_hold ##1 !task2_restart)
    else $error("task 2 not rewound and held after finishing");
  capture_load_a: assert property (@(posedge core_clk) disable iff (rst)
    irq_event && !ctl_rst && (st.w_mode == `EIFS_MODE_HOLD) |=> capture_pos == $past(cap_val))
    else $error("capture register missed interrupt position");
  kernel_sync_a: assert property (@(posedge core_clk) disable iff (rst)
    (st.w_mode == `EIFS_MODE_SYNC) && st.realign_pend && kernel_tick && !ctl_rst |=> kernel_realign)
    else $error("kernel not realigned on tick");
  capture_only_a: assert property (@(posedge core_clk) disable iff (rst)
    (st.w_mode == `EIFS_MODE_CAPT) && irq_event && !ctl_rst
    |=> !task2_restart && !kernel_realign && !final_segment_go && (capture_pos == $past(cap_val)))
    else $error("capture-only mode took extra action");
  term_go_a: assert property (@(posedge core_clk) disable iff (rst)
    (st.w_mode == `EIFS_MODE_TERM) && irq_event && seq_active && !seq_last && !ctl_rst |=> final_segment_go)
    else $error("final segment not launched");
  term_last_a: assert property (@(posedge core_clk) disable iff (rst)
    (st.w_mode == `EIFS_MODE_TERM) && seq_last |=> !final_segment_go)
    else $error("interrupt in final segment not ignored");
  rd_up_a: assert property (@(posedge core_clk) disable iff (rst)
    (st.w_res == `EIFS_RES_DYN) && !ctl_rst && (16'(rd_rate) > `EIFS_RD_UP_CPS)
    |=> st.rd_14 && (rd_conv_sel == RD_CONV_14))
    else $error("dynamic mode did not enter 14-bit tracking");
  rd_dn_a: assert property (@(posedge core_clk) disable iff (rst)
    (st.w_res == `EIFS_RES_DYN) && st.rd_14 && !ctl_rst && (16'(rd_rate) >= `EIFS_RD_DN_CPS) |=> st.rd_14)
    else $error("dynamic mode left 14-bit tracking inside hysteresis");
  cfg_defer_a: assert property (@(posedge core_clk) disable iff (rst)
    !ctl_rst |=> $stable(st.w_trig) && $stable(st.w_src))
    else $error("trigger or source changed without controller reset");
  cfg_apply_a: assert property (@(posedge core_clk) disable iff (rst)
    ctl_rst |=> (st.w_mode == $past(st.cfg_mode)) && (st.w_cap == $past(st.cfg_cap)))
    else $error("working selections not loaded on controller reset");

endmodule

/* File: src/eifs_cfg.svh */
// constants for the external interrupt and feedback select block
`ifndef EIFS_CFG_SVH
`define EIFS_CFG_SVH

`define EIFS_OFS_CFG      8'h00
`define EIFS_OFS_CTRL     8'h04
`define EIFS_OFS_STATUS   8'h08
`define EIFS_OFS_CAPTURE  8'h0C
`define EIFS_OFS_RDPOS    8'h10

`define EIFS_F_MODE       0
`define EIFS_F_TRIG       4
`define EIFS_F_SRC        8
`define EIFS_F_RES        12
`define EIFS_F_VEL        16
`define EIFS_F_CAP        20
`define EIFS_F_FLAGS      24
`define EIFS_C_CTLRST     0
`define EIFS_C_IRQCLR     1

`define EIFS_RST_MODE     3'h0
`define EIFS_RST_TRIG     3'h4
`define EIFS_RST_SRC      2'h2
`define EIFS_RST_RES      3'h4
`define EIFS_RST_VEL      3'h1
`define EIFS_RST_CAP      3'h1

`define EIFS_MODE_OFF     3'h0
`define EIFS_MODE_ICPT    3'h1
`define EIFS_MODE_HOLD    3'h2
`define EIFS_MODE_SYNC    3'h3
`define EIFS_MODE_CAPT    3'h4
`define EIFS_MODE_TERM    3'h5

`define EIFS_TRIG_ULVL    3'h1
`define EIFS_TRIG_UEDGE   3'h2
`define EIFS_TRIG_LLVL    3'h3
`define EIFS_TRIG_LEDGE   3'h4

`define EIFS_SRC_XBUS     2'h1
`define EIFS_SRC_EXTIN    2'h2

`define EIFS_RES_16       3'h1
`define EIFS_RES_14       3'h2
`define EIFS_RES_12       3'h3
`define EIFS_RES_DYN      3'h4

`define EIFS_SEL_OFF      3'h0
`define EIFS_SEL_ENC1     3'h1
`define EIFS_SEL_ENC2     3'h2
`define EIFS_SEL_PORT     3'h3
`define EIFS_SEL_RD       3'h4

`define EIFS_RD_UP_CPS    16'h000F
`define EIFS_RD_DN_CPS    16'h000D
`define EIFS_HSIZE_WORD   3'h2

`endif

/* File: src/eifs_pkg.sv */
// types shared by the external interrupt and feedback select block
package eifs_pkg;

  typedef enum logic [1:0] {
    T2_HELD = 2'h0,
    T2_RUN  = 2'h1,
    T2_FREE = 2'h3
  } eifs_t2_state_t;

  typedef enum logic [1:0] {
    RD_CONV_16 = 2'h0,
    RD_CONV_14 = 2'h1,
    RD_CONV_12 = 2'h2
  } eifs_rd_conv_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic pending;
    logic event_q;
  } eifs_qual_state_t;

endpackage

/* File: src/eifs_irq_qual.sv */
// interrupt line synchroniser and trigger qualifier
`timescale 1ns/1ns
module eifs_irq_qual
  import eifs_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       irq_line_n,
  input  wire logic [2:0] trig_type,
  input  wire logic       pend_clear,
  output logic            irq_event,
  output logic            irq_pending
);
`include "eifs_cfg.svh"

  localparam eifs_qual_state_t QUAL_RST = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0};

  eifs_qual_state_t st;
  eifs_qual_state_t next_st;
  logic             latched;
  logic             low;
  logic             fall;
  logic             hit;

  always_comb begin
    next_st       = st;
    next_st.sync1 = irq_line_n;
    next_st.sync2 = st.sync1;
    next_st.prev  = st.sync2;
    low           = !st.sync2;
    fall          = st.prev && !st.sync2;
    latched       = (trig_type == `EIFS_TRIG_LLVL) || (trig_type == `EIFS_TRIG_LEDGE);
    case (trig_type)
      `EIFS_TRIG_ULVL:  hit = low;
      `EIFS_TRIG_UEDGE: hit = fall;
      // a trigger in the clear cycle wins over the clear
      `EIFS_TRIG_LLVL:  hit = low && (!st.pending || pend_clear);
      `EIFS_TRIG_LEDGE: hit = fall && (!st.pending || pend_clear);
      default:          hit = 1'h0;
    endcase
    next_st.event_q = hit;
    if (latched) begin
      next_st.pending = hit || (st.pending && !pend_clear);
    end else begin
      next_st.pending = low;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= QUAL_RST;
    end else begin
      st <= next_st;
    end
  end

  assign irq_event   = st.event_q;
  assign irq_pending = st.pending;

  latch_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    (trig_type == `EIFS_TRIG_LEDGE) && st.pending && !pend_clear |=> st.pending && !st.event_q)
    else $error("latched interrupt lost or retriggered");
  edge_once_a: assert property (@(posedge core_clk) disable iff (rst)
    (trig_type == `EIFS_TRIG_UEDGE) && st.event_q |=> !st.event_q)
    else $error("edge trigger gave two events");

endmodule

/* File: bench/eifs_evt_model.sv */
// far-side model: interrupt lines and kernel tick
`timescale 1ns/1ns
module eifs_evt_model (
  input  wire logic core_clk,
  input  wire logic fire,
  input  wire logic use_bus,
  output logic      bus_irq_n,
  output logic      ext_irq_n,
  output logic      kernel_tick
);
  logic [2:0] low_cnt  = 3'h0;
  logic [2:0] tick_cnt = 3'h0;
  always @(posedge core_clk) begin
    tick_cnt <= tick_cnt + 3'h1;
    if (fire)
      low_cnt <= 3'h3;
    else if (low_cnt != 3'h0)
      low_cnt <= low_cnt - 3'h1;
  end
  assign kernel_tick = (tick_cnt == 3'h7);
  // lines are pulled high while idle; one low burst per request
  assign bus_irq_n = !(use_bus && low_cnt != 3'h0);
  assign ext_irq_n = !(!use_bus && low_cnt != 3'h0);
endmodule

/* File: bench/eifs_tb_top.sv */
// testbench for the external interrupt and feedback select block
`timescale 1ns/1ns
`include "eifs_cfg.svh"
module eifs_tb_top;
  import eifs_pkg::*;
  logic          core_clk = 0, rst = 1, hsel = 1, hwrite = 0, fire = 0, on_bus = 0, t2_done = 0, t1_end = 0;
  logic          seq_act = 0, seq_lst = 0, ready, bus_n, ext_n, tick, t2h, ral, go, vfe, t1h, t2r, rsp;
  logic [31:0]   pp = 32'h0;
  logic [1:0]    htrans = 2'h0;
  logic [2:0]    hsize = 3'h2;
  logic [2:0]    vsel;
  logic [15:0]   rd_raw = 16'h0, rd_rate = 16'h0;
  logic [31:0]   haddr = 32'h0, hwdata = 32'h0, e1 = 32'h0, e2 = 32'h0, rdat, cap, rpos, w, prev, nv;
  int            n_errors = 0, num_checks = 0, n_go = 0, n_ral = 0;
  eifs_rd_conv_t conv;
  always #25 core_clk = ~core_clk;
  eifs_evt_model far (.core_clk(core_clk), .fire(fire), .use_bus(on_bus), .bus_irq_n(bus_n),
    .ext_irq_n(ext_n), .kernel_tick(tick));
  eifs_top dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(ready), .hrdata(rdat), .hreadyout(ready),
    .hresp(rsp), .ext_bus_irq_n(bus_n), .ext_input_irq_n(ext_n), .enc1_pos(e1), .enc2_pos(e2),
    .port_pos(pp), .rd_raw(rd_raw), .rd_rate(rd_rate), .kernel_tick(tick), .task1_end(t1_end),
    .task2_done(t2_done), .seq_active(seq_act), .seq_last(seq_lst), .task1_hold(t1h), .task2_hold(t2h),
    .task2_restart(t2r), .kernel_realign(ral), .final_segment_go(go), .capture_pos(cap), .rd_pos(rpos),
    .rd_conv_sel(conv), .vel_src_sel(vsel), .vel_fb_enable(vfe));
  always @(posedge core_clk) begin
    n_go += int'(go === 1'b1);
    n_ral += int'(ral === 1'b1);
  end
  function automatic logic [31:0] cw(input int m, t, s, r, v, c);
    return {9'h0, 3'(c), 1'b0, 3'(v), 1'b0, 3'(r), 2'h0, 2'(s), 1'b0, 3'(t), 1'b0, 3'(m)};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge core_clk); while (ready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (ready !== 1'b1);
    w = rdat;
    chk("hresp", rsp, 32'h0);
  endtask
  task automatic cfg(input logic [31:0] v);
    bus(1'b1, `EIFS_OFS_CFG, v);
    bus(1'b1, `EIFS_OFS_CTRL, 32'h1);
    repeat (3) @(posedge core_clk);
  endtask
  task automatic hit(input logic b);
    on_bus <= b;
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    complete_run();
  end
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    prev = cw(0, 4, 2, 4, 1, 1);
    bus(1'b0, `EIFS_OFS_CFG, 32'h0);
    chk("cfg", w, prev);
    chk("vsel", vsel, 32'h1);
    chk("t2hold", t2h, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", w, 32'h0);
    for (int i = 1; i < 5; i++) begin
      nv = cw(0, i, 2 - i % 2, i, i, i);
      bus(1'b1, `EIFS_OFS_CFG, nv);
      bus(1'b0, `EIFS_OFS_STATUS, 32'h0);
      chk("staged", w & 32'h007FFFFF, prev);
      bus(1'b1, `EIFS_OFS_CTRL, 32'h1);
      bus(1'b0, `EIFS_OFS_STATUS, 32'h0);
      chk("working", w & 32'h007FFFFF, nv);
      chk("vsel", vsel, 32'(i));
      if (i < 4)
        chk("conv", conv, 32'(i - 1));
      prev = nv;
    end
    bus(1'b1, `EIFS_OFS_CFG, cw(0, 5, 2, 4, 0, 2));
    bus(1'b0, `EIFS_OFS_CFG, 32'h0);
    chk("badtrig", w, cw(0, 4, 2, 4, 0, 2));
    cfg(cw(0, 4, 2, 4, 0, 2));
    chk("vfe", vfe, 32'h0);
    $display("select tests done");
    cfg(cw(4, 2, 2, 4, 1, 2));
    e2 <= 32'h00001234;
    hit(1'b0);
    chk("cap", cap, 32'h00001234);
    chk("t2hold", t2h, 32'h0);
    e2 <= 32'h00005678;
    hit(1'b0);
    chk("recap", cap, 32'h00005678);
    cfg(cw(2, 4, 1, 4, 1, 1));
    chk("held", t2h, 32'h1);
    e1 <= 32'h0000AAAA;
    hit(1'b1);
    chk("cap", cap, 32'h0000AAAA);
    chk("run", t2h, 32'h0);
    t2_done <= 1'b1;
    @(posedge core_clk);
    t2_done <= 1'b0;
    @(posedge core_clk);
    chk("restart", t2r, 32'h1);
    @(posedge core_clk);
    chk("reheld", t2h, 32'h1);
    chk("restart end", t2r, 32'h0);
    e1 <= 32'h0000BBBB;
    hit(1'b1);
    chk("latched", cap, 32'h0000AAAA);
    bus(1'b1, `EIFS_OFS_CTRL, 32'h2);
    hit(1'b1);
    chk("cleared", cap, 32'h0000BBBB);
    // intercept mode: task 1 held while task 2 runs, task 1 end frees task 2
    cfg(cw(1, 2, 2, 4, 1, 3));
    pp <= 32'h00003333;
    hit(1'b0);
    chk("cap port", cap, 32'h00003333);
    chk("t1hold", t1h, 32'h1);
    t2_done <= 1'b1;
    @(posedge core_clk);
    t2_done <= 1'b0;
    @(posedge core_clk);
    chk("t1free", t1h, 32'h0);
    chk("t2rehold", t2h, 32'h1);
    t1_end <= 1'b1;
    @(posedge core_clk);
    t1_end <= 1'b0;
    @(posedge core_clk);
    chk("t2free", t2h, 32'h0);
    $display("capture tests done");
    cfg(cw(3, 2, 2, 4, 1, 1));
    hit(1'b0);
    repeat (10) @(posedge core_clk);
    chk("realign", 32'(n_ral), 32'h1);
    cfg(cw(5, 2, 2, 4, 1, 1));
    // two-segment sequence in its first segment, then in its last
    seq_act <= 1'b1;
    hit(1'b0);
    chk("go", 32'(n_go), 32'h1);
    seq_lst <= 1'b1;
    hit(1'b0);
    chk("go last", 32'(n_go), 32'h1);
    rd_raw <= 16'h0123;
    rd_rate <= 16'h0010;
    repeat (3) @(posedge core_clk);
    chk("conv up", conv, RD_CONV_14);
    chk("rdpos", rpos, 32'h0000048C);
    rd_rate <= 16'h000E;
    repeat (3) @(posedge core_clk);
    chk("conv hys", conv, RD_CONV_14);
    rd_rate <= 16'h000C;
    repeat (3) @(posedge core_clk);
    chk("conv dn", conv, RD_CONV_16);
    chk("rdpos", rpos, 32'h00000123);
    $display("mode tests done");
    complete_run();
  end
endmodule
